// ### src/txmc_map.vh
`ifndef TXMC_MAP_VH
`define TXMC_MAP_VH

// register addresses (7-bit serial address space)
`define TXMC_ADR_DEV        7'h0e
`define TXMC_ADR_RATE       7'h0f
`define TXMC_ADR_FDIV       7'h10
`define TXMC_ADR_ASKCFG     7'h11
`define TXMC_ADR_ADIV       7'h12
`define TXMC_ADR_MODE       7'h0b
`define TXMC_ADR_PA         7'h13

// reset values
`define TXMC_RST_DEV        8'h4b
`define TXMC_RST_RATE       8'h24
`define TXMC_RST_FDIV       8'h34
`define TXMC_RST_ASKCFG     8'h3f
`define TXMC_RST_ADIV       8'hb4
`define TXMC_RST_MODE       8'h00
`define TXMC_RST_PA         8'h00

// field positions
`define TXMC_MODE_LSB       0
`define TXMC_FEXP_LSB       3
`define TXMC_FDIV_LSB       0
`define TXMC_AEXP_LSB       6
`define TXMC_ADIV_LSB       0
`define TXMC_DEPTH_LSB      0
`define TXMC_SHAPE_LSB      3
`define TXMC_AKON_BIT       6
`define TXMC_DSEL_BIT       7
`define TXMC_MANCH_BIT      2

// modulation types
`define TXMC_MT_VCO_CL      2'd0
`define TXMC_MT_VCO_OL      2'd1
`define TXMC_MT_DIVIDER     2'd2
`define TXMC_MT_ASK         2'd3

// prescaler base exponents and dither seed
`define TXMC_FSK_BASE_EXP   3
`define TXMC_ASK_BASE_EXP   5
`define TXMC_PN_SEED        4'h1

`endif

// ### src/txmc_core.v
// How it works
// [RULE_01] mode 0: data straight to oscillator, loop stays active, data must be DC-free
// [RULE_02] mode 1, pin data: loop active when input floats, off when driven
// [RULE_03] mode 1, serial data: loop off during each packet, on otherwise
// [RULE_04] mode 2: data bit picks one of two stored divider sets
// [RULE_05] amplitude keying only when enable bit set and mode is 3
// [RULE_06] zero-symbol level is (output level minus depth step) times 3 dB
// [RULE_07] output level not above depth step: zero symbols fully off
// [RULE_08] 3-bit edge shaping field, 7 strongest
// [RULE_09] host should pick stronger shaping at lower amplitude bit rates
// [RULE_10] spread amplitude keying dithers frequency via divider switching
// [RULE_11] dither select: 0 alternating, 1 repeating 15-bit sequence
// [RULE_12] frequency bit rate = xtal / (divisor * 2^(3+exponent))
// [RULE_13] amplitude bit rate = xtal / (divisor * 2^(5+exponent))
// [RULE_14] dither sequence clocked at the frequency-keying rate
// [RULE_15] host keeps frequency exponent nonzero when biphase coding is on
// [RULE_16] every data edge pulses the charge pump for one modulator clock (code pulses only in modes 0 and 1)
// [RULE_17] each rate generator: divisor reload counter then power-of-two prescaler
`timescale 1ns/1ps
`include "txmc_map.vh"

module txmc_core
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // register port
  input  wire       reg_wr,
  input  wire [6:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // transmit data
  input  wire       tx_data,
  input  wire       tx_pin_driven,
  input  wire       tx_pin_mode,
  input  wire       packet_active,
  // modulator outputs
  output reg        pll_enable,
  output reg        vco_data,
  output reg        divider_set_sel,
  output reg        ask_active,
  output reg        ask_level,
  output reg  [2:0] ask_off_power,
  output reg        ask_ook,
  output reg  [2:0] ask_shape,
  output reg        pump_pulse,
  output reg        pump_dir,
  output reg  [4:0] pump_current,
  output reg  [2:0] pump_atten,
  output reg        fsk_strobe,
  output reg        ask_strobe
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [7:0] dev_q;
  reg  [7:0] rate_q;
  reg  [7:0] fdiv_q;
  reg  [7:0] askcfg_q;
  reg  [7:0] adiv_q;
  reg  [7:0] mode_q;
  reg  [7:0] pa_q;

  wire [1:0] mod_type      = mode_q[`TXMC_MODE_LSB +: 2];
  wire [2:0] freq_rate_exponent = rate_q[`TXMC_FEXP_LSB +: 3];
  wire [5:0] freq_rate_divisor  = fdiv_q[`TXMC_FDIV_LSB +: 6];
  wire [1:0] amp_rate_exponent  = adiv_q[`TXMC_AEXP_LSB +: 2];
  wire [5:0] amp_rate_divisor   = adiv_q[`TXMC_ADIV_LSB +: 6];
  wire [2:0] depth_step_code    = askcfg_q[`TXMC_DEPTH_LSB +: 3];
  wire [2:0] amp_edge_shaping   = askcfg_q[`TXMC_SHAPE_LSB +: 3];
  wire       amplitude_keying_on = askcfg_q[`TXMC_AKON_BIT];
  wire       dither_sequence_select = askcfg_q[`TXMC_DSEL_BIT];
  wire [2:0] output_level_code  = pa_q[2:0];

  always @(posedge clk)
  begin
    if (rst)
    begin
      dev_q    <= `TXMC_RST_DEV;
      rate_q   <= `TXMC_RST_RATE;
      fdiv_q   <= `TXMC_RST_FDIV;
      askcfg_q <= `TXMC_RST_ASKCFG;
      adiv_q   <= `TXMC_RST_ADIV;
      mode_q   <= `TXMC_RST_MODE;
      pa_q     <= `TXMC_RST_PA;
    end
    else if (reg_wr)
    begin
      // unmapped addresses fall through and change nothing
      case (reg_addr)
        `TXMC_ADR_DEV:    dev_q    <= reg_wdata;
        `TXMC_ADR_RATE:   rate_q   <= reg_wdata;
        `TXMC_ADR_FDIV:   fdiv_q   <= reg_wdata;
        `TXMC_ADR_ASKCFG: askcfg_q <= reg_wdata;
        `TXMC_ADR_ADIV:   adiv_q   <= reg_wdata;
        `TXMC_ADR_MODE:   mode_q   <= reg_wdata;
        `TXMC_ADR_PA:     pa_q     <= reg_wdata;
        default:          dev_q    <= dev_q;
      endcase
    end
  end

  // unmapped addresses read zero
  always @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        `TXMC_ADR_DEV:    reg_rdata <= dev_q;
        `TXMC_ADR_RATE:   reg_rdata <= rate_q;
        `TXMC_ADR_FDIV:   reg_rdata <= fdiv_q;
        `TXMC_ADR_ASKCFG: reg_rdata <= askcfg_q;
        `TXMC_ADR_ADIV:   reg_rdata <= adiv_q;
        `TXMC_ADR_MODE:   reg_rdata <= mode_q;
        `TXMC_ADR_PA:     reg_rdata <= pa_q;
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bit-rate generators
  // ---------------------------------------------------------------
  // divisor 0 treated as 1 so the counter never stalls
  function [5:0] txmc_div_top;
    input [5:0] k;
    begin
      txmc_div_top = (k == 6'h00) ? 6'h00 : k - 6'h01;
    end
  endfunction

  reg  [5:0]  fk_cnt_q;
  reg  [9:0]  fk_pre_q;
  reg  [5:0]  ak_cnt_q;
  reg  [9:0]  ak_pre_q;
  wire        fk_tick = (fk_cnt_q == txmc_div_top(freq_rate_divisor)); // RULE_17
  wire        ak_tick = (ak_cnt_q == txmc_div_top(amp_rate_divisor)); // RULE_17
  // exponents above the documented range clamp to the largest legal one
  wire [2:0]  fexp = (freq_rate_exponent > 3'd5) ? 3'd5 : freq_rate_exponent;
  wire [9:0]  fk_pre_top = (10'h008 << fexp) - 10'h001; // RULE_12
  wire [9:0]  ak_pre_top = (10'h020 << amp_rate_exponent) - 10'h001; // RULE_13
  wire        fk_bit = fk_tick && (fk_pre_q == fk_pre_top);
  wire        ak_bit = ak_tick && (ak_pre_q == ak_pre_top);

  always @(posedge clk)
  begin
    if (rst)
    begin
      fk_cnt_q <= 6'h00;
      fk_pre_q <= 10'h000;
      ak_cnt_q <= 6'h00;
      ak_pre_q <= 10'h000;
    end
    else
    begin
      fk_cnt_q <= fk_tick ? 6'h00 : fk_cnt_q + 6'h01; // RULE_17
      if (fk_tick)
        fk_pre_q <= (fk_pre_q >= fk_pre_top) ? 10'h000 : fk_pre_q + 10'h001; // RULE_12
      ak_cnt_q <= ak_tick ? 6'h00 : ak_cnt_q + 6'h01; // RULE_17
      if (ak_tick)
        ak_pre_q <= (ak_pre_q >= ak_pre_top) ? 10'h000 : ak_pre_q + 10'h001; // RULE_13
    end
  end

  // ---------------------------------------------------------------
  // dither sequence
  // ---------------------------------------------------------------
  // 4-bit lfsr, new msb = bit0 ^ bit3, period 15
  // from seed 0001 the output is 111101011001000 entered at its
  // last four bits; the phase is free, only the bit order matters
  // to a receiver that sees nothing but the dithered carrier
  reg  [3:0] pn_q;
  reg        alt_q;
  wire       dither_bit = dither_sequence_select ? pn_q[0] : alt_q; // RULE_11

  always @(posedge clk)
  begin
    if (rst)
    begin
      pn_q  <= `TXMC_PN_SEED;
      alt_q <= 1'b0;
    end
    else if (fk_bit) // RULE_14
    begin
      pn_q  <= {pn_q[0] ^ pn_q[3], pn_q[3:1]}; // RULE_11
      alt_q <= ~alt_q; // RULE_11
    end
  end

  // ---------------------------------------------------------------
  // mode control
  // ---------------------------------------------------------------
  wire ask_sel = amplitude_keying_on && (mod_type == `TXMC_MT_ASK); // RULE_05
  reg  data_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      pll_enable      <= 1'b1;
      vco_data        <= 1'b0;
      divider_set_sel <= 1'b0;
      ask_active      <= 1'b0;
      ask_level       <= 1'b0;
      ask_off_power   <= 3'd0;
      ask_ook         <= 1'b0;
      ask_shape       <= 3'd0;
      fsk_strobe      <= 1'b0;
      ask_strobe      <= 1'b0;
    end
    else
    begin
      fsk_strobe <= fk_bit;
      ask_strobe <= ak_bit;
      ask_active <= ask_sel; // RULE_05
      ask_shape  <= amp_edge_shaping; // RULE_08
      ask_level  <= ask_sel & tx_data;
      // zero-symbol level: depth steps of 3 dB below the one level
      ask_ook    <= (output_level_code <= depth_step_code); // RULE_07
      ask_off_power <= (output_level_code <= depth_step_code) ? 3'd0 :
                       output_level_code - depth_step_code; // RULE_06
      case (mod_type)
        `TXMC_MT_VCO_CL:
        begin
          pll_enable      <= 1'b1; // RULE_01
          vco_data        <= tx_data; // RULE_01
          divider_set_sel <= 1'b0;
        end
        `TXMC_MT_VCO_OL:
        begin
          if (tx_pin_mode)
            pll_enable <= ~tx_pin_driven; // RULE_02
          else
            pll_enable <= ~packet_active; // RULE_03
          vco_data        <= tx_data;
          divider_set_sel <= 1'b0;
        end
        `TXMC_MT_DIVIDER:
        begin
          pll_enable      <= 1'b1;
          vco_data        <= 1'b0;
          divider_set_sel <= tx_data; // RULE_04
        end
        `TXMC_MT_ASK:
        begin
          pll_enable      <= 1'b1;
          vco_data        <= 1'b0;
          // spreading rides on divider switching
          divider_set_sel <= ask_sel & dither_bit; // RULE_10
        end
        default:
        begin
          pll_enable      <= 1'b1;
          vco_data        <= 1'b0;
          divider_set_sel <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // charge pump
  // ---------------------------------------------------------------
  // pulse width is one modulator clock, i.e. divisor crystal cycles
  reg [5:0] pump_cnt_q;
  wire      vco_mode = (mod_type == `TXMC_MT_VCO_CL) || (mod_type == `TXMC_MT_VCO_OL);
  wire      data_edge = vco_mode && (tx_data != data_q);

  always @(posedge clk)
  begin
    if (rst)
    begin
      data_q       <= 1'b0;
      pump_cnt_q   <= 6'h00;
      pump_pulse   <= 1'b0;
      pump_dir     <= 1'b0;
      pump_current <= 5'd0;
      pump_atten   <= 3'd0;
    end
    else
    begin
      data_q       <= tx_data;
      pump_current <= dev_q[7:3]; // RULE_16
      pump_atten   <= dev_q[2:0];
      // a new data edge during a pulse restarts its width
      if (data_edge)
      begin
        pump_pulse <= 1'b1; // RULE_16
        pump_dir   <= tx_data;
        pump_cnt_q <= txmc_div_top(freq_rate_divisor); // RULE_16
      end
      else if (pump_cnt_q != 6'h00)
        pump_cnt_q <= pump_cnt_q - 6'h01;
      else
        pump_pulse <= 1'b0;
    end
  end

endmodule

// ### verification/txmc_chk.sv
`timescale 1ns/1ps
`include "txmc_map.vh"
module txmc_chk
(
  // clock and reset
  input logic       clk,
  input logic       rst,
  // register port
  input logic       reg_wr,
  input logic [6:0] reg_addr,
  input logic [7:0] reg_wdata,
  // transmit data
  input logic       tx_data,
  input logic       tx_pin_driven,
  input logic       tx_pin_mode,
  input logic       packet_active,
  // modulator outputs
  input logic       pll_enable,
  input logic       vco_data,
  input logic       divider_set_sel,
  input logic       ask_active,
  input logic [2:0] ask_off_power,
  input logic       ask_ook,
  input logic [2:0] ask_shape,
  input logic       pump_pulse
);
  // ----------
  // shadow registers
  // ----------
  logic [1:0] md_q;
  logic [7:0] ac_q;
  logic [2:0] pa_q;
  logic       ak;
  always @(posedge clk)
  begin
    if (rst)
    begin
      md_q <= 2'h0;
      ac_q <= `TXMC_RST_ASKCFG;
      pa_q <= 3'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `TXMC_ADR_MODE) md_q <= reg_wdata[1:0];
      if (reg_addr == `TXMC_ADR_ASKCFG) ac_q <= reg_wdata;
      if (reg_addr == `TXMC_ADR_PA) pa_q <= reg_wdata[2:0];
    end
  end
  assign ak = md_q == 2'h3 && ac_q[6];
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_toggle;
    md_q == 2'h0 && tx_data != $past(tx_data);
  endsequence
  a_closed_loop:
    assert property (md_q == 2'h0 |=> pll_enable && vco_data == $past(tx_data))
    else $error("closed loop path wrong");
  a_pin_open:
    assert property (md_q == 2'h1 && tx_pin_mode |=> pll_enable == !$past(tx_pin_driven))
    else $error("pin open loop gating wrong");
  a_pkt_open:
    assert property (md_q == 2'h1 && !tx_pin_mode |=> pll_enable == !$past(packet_active))
    else $error("packet open loop gating wrong");
  a_div_key:
    assert property (md_q == 2'h2 |=> divider_set_sel == $past(tx_data))
    else $error("divider set not following data");
  a_ask_select:
    assert property (1'b1 |=> ask_active == $past(ak))
    else $error("amplitude keying select wrong");
  a_ask_depth:
    assert property (ak && pa_q > ac_q[2:0] |=> !ask_ook && ask_off_power == $past(pa_q - ac_q[2:0]))
    else $error("amplitude depth wrong");
  a_ask_ook:
    assert property (ak && pa_q <= ac_q[2:0] |=> ask_ook && ask_off_power == 3'h0)
    else $error("on-off keying not selected");
  a_ask_shape:
    assert property (ak |=> ask_shape == $past(ac_q[5:3]))
    else $error("shaping field not passed");
  a_pump_kick:
    assert property (s_toggle |-> ##[1:2] pump_pulse)
    else $error("no pump pulse after data edge");
endmodule

bind txmc_core txmc_chk txmc_chk_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .tx_data(tx_data),
  .tx_pin_driven(tx_pin_driven), .tx_pin_mode(tx_pin_mode), .packet_active(packet_active),
  .pll_enable(pll_enable), .vco_data(vco_data), .divider_set_sel(divider_set_sel),
  .ask_active(ask_active), .ask_off_power(ask_off_power), .ask_ook(ask_ook),
  .ask_shape(ask_shape), .pump_pulse(pump_pulse));

// ### verification/txmc_host.sv
`timescale 1ns/1ps
module txmc_host
(
  // clock
  input  logic       clk,
  // register port
  output logic       reg_wr,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  input  logic [7:0] reg_rdata,
  // transmit data
  output logic       tx_data,
  output logic       tx_pin_driven,
  output logic       tx_pin_mode,
  output logic       packet_active
);
  // ----------
  // host side
  // ----------
  initial
  begin
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    tx_data = 1'b0;
    tx_pin_driven = 1'b0;
    tx_pin_mode = 1'b0;
    packet_active = 1'b0;
  end
  // a floating pin must not look like held data
  always @(negedge clk)
    if (tx_pin_mode && !tx_pin_driven) tx_data <= ~tx_data;
  // caller keeps shaping sane; t_dither writes a zero freq exponent
  task wr(input logic [6:0] a, input logic [7:0] d);
  begin
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input logic [6:0] a, output logic [7:0] d);
  begin
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  end
  endtask
  task drv(input logic d, input logic pd, input logic pm, input logic pk);
  begin
    @(negedge clk);
    tx_data = d;
    tx_pin_driven = pd;
    tx_pin_mode = pm;
    packet_active = pk;
  end
  endtask
endmodule

// ### verification/txmc_core_tb.sv
`timescale 1ns/1ps
`include "txmc_map.vh"
module txmc_core_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire reg_wr, tx_data, tx_pin_driven, tx_pin_mode, packet_active;
  wire [6:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata;
  wire pll_enable, vco_data, divider_set_sel, ask_active, ask_level, ask_ook;
  wire pump_pulse, pump_dir, fsk_strobe, ask_strobe;
  wire [2:0] ask_off_power, ask_shape, pump_atten;
  wire [4:0] pump_current;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] d;
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  txmc_host txmc_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_data(tx_data),
    .tx_pin_driven(tx_pin_driven), .tx_pin_mode(tx_pin_mode), .packet_active(packet_active));
  txmc_core txmc_core_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_data(tx_data),
    .tx_pin_driven(tx_pin_driven), .tx_pin_mode(tx_pin_mode), .packet_active(packet_active),
    .pll_enable(pll_enable), .vco_data(vco_data), .divider_set_sel(divider_set_sel),
    .ask_active(ask_active), .ask_level(ask_level), .ask_off_power(ask_off_power),
    .ask_ook(ask_ook), .ask_shape(ask_shape), .pump_pulse(pump_pulse), .pump_dir(pump_dir),
    .pump_current(pump_current), .pump_atten(pump_atten), .fsk_strobe(fsk_strobe),
    .ask_strobe(ask_strobe));
  // ----------
  // helpers
  // ----------
  task chk(input logic [7:0] g, input logic [7:0] e);
  begin
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wstb(input logic a);
    int i;
  begin
    step(1);
    for (i = 0; i < 600 && (a ? ask_strobe : fsk_strobe) !== 1'b1; i++)
      step(1);
  end
  endtask
  task per(input logic a);
    int t;
  begin
    wstb(a);
    t = cyc;
    wstb(a);
    chk(8'(cyc - t), a ? 8'h40 : 8'h30);
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // ----------
  // scenarios
  // ----------
  task t_regs;
  begin
    txmc_host_inst.rd(`TXMC_ADR_RATE, d);
    chk(d, `TXMC_RST_RATE);
    txmc_host_inst.rd(`TXMC_ADR_FDIV, d);
    chk(d, `TXMC_RST_FDIV);
    txmc_host_inst.wr(`TXMC_ADR_DEV, 8'h5a);
    txmc_host_inst.rd(`TXMC_ADR_DEV, d);
    chk(d, 8'h5a);
    chk({pump_current, pump_atten}, 8'h5a);
    txmc_host_inst.rd(7'h20, d);
    chk(d, 8'h00);
    $display("regs done");
  end
  endtask
  task t_loops;
    int w;
  begin
    txmc_host_inst.wr(`TXMC_ADR_FDIV, 8'h04);
    txmc_host_inst.drv(1'b1, 1'b1, 1'b0, 1'b0);
    step(2);
    chk(8'({pll_enable, vco_data}), 8'h03);
    txmc_host_inst.drv(1'b0, 1'b1, 1'b0, 1'b0);
    w = 0;
    repeat (12)
    begin
      step(1);
      if (pump_pulse === 1'b1) w++;
    end
    chk(8'(w), 8'h04);
    chk(8'(pump_dir), 8'h00);
    txmc_host_inst.wr(`TXMC_ADR_MODE, 8'h01);
    txmc_host_inst.drv(1'b1, 1'b1, 1'b1, 1'b0);
    step(2);
    chk(8'({pll_enable, vco_data}), 8'h01);
    txmc_host_inst.drv(1'b0, 1'b0, 1'b1, 1'b0);
    step(2);
    chk(8'(pll_enable), 8'h01);
    txmc_host_inst.drv(1'b0, 1'b0, 1'b0, 1'b1);
    step(2);
    chk(8'(pll_enable), 8'h00);
    txmc_host_inst.drv(1'b0, 1'b0, 1'b0, 1'b0);
    step(2);
    chk(8'(pll_enable), 8'h01);
    txmc_host_inst.wr(`TXMC_ADR_MODE, 8'h02);
    txmc_host_inst.drv(1'b1, 1'b0, 1'b0, 1'b0);
    step(2);
    chk(8'(divider_set_sel), 8'h01);
    $display("loops done");
  end
  endtask
  task t_ask;
  begin
    txmc_host_inst.wr(`TXMC_ADR_ASKCFG, 8'h6c);
    txmc_host_inst.wr(`TXMC_ADR_PA, 8'h07);
    chk(8'(ask_active), 8'h00);
    txmc_host_inst.wr(`TXMC_ADR_MODE, 8'h03);
    step(2);
    chk(8'(ask_active), 8'h01);
    chk({ask_level, ask_ook, ask_off_power, ask_shape}, 8'h9d);
    txmc_host_inst.wr(`TXMC_ADR_PA, 8'h04);
    step(2);
    chk(8'(ask_active), 8'h01);
    chk({ask_level, ask_ook, ask_off_power, ask_shape}, 8'hc5);
    txmc_host_inst.wr(`TXMC_ADR_ASKCFG, 8'h2c);
    step(2);
    chk(8'(ask_active), 8'h00);
    $display("ask done");
  end
  endtask
  task t_rate;
  begin
    txmc_host_inst.wr(`TXMC_ADR_RATE, 8'h08);
    txmc_host_inst.wr(`TXMC_ADR_FDIV, 8'h03);
    per(1'b0);
    txmc_host_inst.wr(`TXMC_ADR_ADIV, 8'h02);
    per(1'b1);
    $display("rate done");
  end
  endtask
  task t_dither;
    logic [30:0] s;
    logic        ok;
    logic        hit;
    int          r;
    int          i;
  begin
    txmc_host_inst.wr(`TXMC_ADR_RATE, 8'h00);
    txmc_host_inst.wr(`TXMC_ADR_FDIV, 8'h01);
    txmc_host_inst.wr(`TXMC_ADR_ASKCFG, 8'hc0);
    for (i = 0; i < 31; i++)
    begin
      wstb(1'b0);
      step(4);
      s[i] = divider_set_sel;
    end
    // any phase of 111101011001000 is accepted
    ok = 1'b0;
    for (r = 0; r < 15; r++)
    begin
      hit = 1'b1;
      for (i = 1; i < 31; i++)
        if (s[i] !== ((15'h7ac8 >> (14 - (i + r) % 15)) & 15'h0001)) hit = 1'b0;
      if (hit) ok = 1'b1;
    end
    chk(8'(ok), 8'h01);
    txmc_host_inst.wr(`TXMC_ADR_ASKCFG, 8'h40);
    for (i = 0; i < 5; i++)
    begin
      wstb(1'b0);
      step(4);
      s[i] = divider_set_sel;
    end
    chk(8'({s[1] ^ s[2], s[2] ^ s[3], s[3] ^ s[4]}), 8'h07);
    $display("dither done");
  end
  endtask
  initial
  begin
    #(100 * 5000);
    n_errors++;
    $display("watchdog expired");
    report_and_stop;
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_regs;
    t_loops;
    t_ask;
    t_rate;
    t_dither;
    report_and_stop;
  end
endmodule
